// [hdl/vbc_osc_port.sv]
/*
 Oscillator serial port shifter: 16 bits, one transfer per 20 ticks.
 Assumes tick pulses at the sequencer clock rate.
*/
module vbc_osc_port (
    input wire logic ref_clk,
    input wire logic sys_rst,
    vbc_osc_port_if.port lnk
);
    import vbc_pkg::*;
    logic [15:0] sh_q;
    logic [4:0] cnt_q;
    logic busy_q;
    logic done_q;
    assign lnk.busy = busy_q;
    assign lnk.done = done_q;
    assign lnk.sdata = sh_q[15];
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sh_q <= 16'h0000;
            cnt_q <= 5'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (!busy_q && lnk.start) begin
                sh_q <= lnk.word;
                cnt_q <= 5'h00;
                busy_q <= 1'b1;
            end else if (busy_q && lnk.tick) begin
                if (cnt_q < 5'(XFER_BITS)) begin
                    sh_q <= {sh_q[14:0], 1'b0};
                end
                if (cnt_q == 5'(XFER_TICKS - 1)) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end
endmodule : vbc_osc_port

// [hdl/vbc_osc_port_if.sv]
/*
 Link between sequencer and oscillator serial port shifter.
 Assumes both ends share ref_clk.
*/
interface vbc_osc_port_if;
    logic start;
    logic tick;
    logic [15:0] word;
    logic busy;
    logic done;
    logic sdata;
    modport seq (output start, output tick, output word, input busy, input done,
        input sdata);
    modport port (input start, input tick, input word, output busy, output done,
        output sdata);
endinterface : vbc_osc_port_if

// [hdl/vbc_pkg.sv]
/*
 Constants, register map and types of the VCO band calibration sequencer.
 Assumes a single clock ref_clk and a synchronous active-high reset.
*/
package vbc_pkg;
    localparam int REG_W = 24;
    localparam logic [4:0] ADR_REF_DIV = 5'h02;
    localparam logic [4:0] ADR_INT_DIV = 5'h03;
    localparam logic [4:0] ADR_FRAC_DIV = 5'h04;
    localparam logic [4:0] ADR_DSM_CFG = 5'h06;
    localparam logic [4:0] ADR_LD_CFG = 5'h07;
    localparam logic [4:0] ADR_CP_CFG = 5'h09;
    localparam logic [4:0] ADR_CAL_CFG = 5'h0A;
    localparam logic [4:0] ADR_EXACT_CFG = 5'h0C;
    localparam logic [4:0] ADR_LDPIN_CFG = 5'h0F;
    localparam logic [4:0] ADR_SW_SET = 5'h15;
    localparam logic [4:0] ADR_OUT_DIVG = 5'h16;
    localparam logic [4:0] ADR_OUT_CFG = 5'h17;
    localparam int BIT_FRAC_MODE = 11;
    localparam int BIT_CAL_OFF = 11;
    localparam int BIT_RELOCK = 17;
    localparam int MLEN_LSB = 0;
    localparam int MCLK_LSB = 13;
    localparam int SW_LSB = 1;
    localparam int SW_W = 8;
    localparam int ODIV_LSB = 0;
    localparam int ODIV_W = 6;
    localparam int GAIN_LSB = 6;
    localparam int GAIN_W = 5;
    localparam int BIT_CAL_MUTE = 7;
    localparam int BAND_BITS = 5;
    localparam int XFER_TICKS = 20;
    localparam int XFER_COUNT = 7;
    localparam int XFER_BITS = 16;
    localparam int SETTLE_TICKS = 128;
    localparam int SETTLE_COUNT = 3;
    localparam int MEAS_MAX = BAND_BITS + 1;
    localparam int FRAC_BITS = 24;
    localparam logic [REG_W-1:0] RST_REG = 24'h000000;
    typedef enum logic [2:0] {
        VBC_IDLE = 3'b000,
        VBC_SETTLE = 3'b001,
        VBC_MEAS = 3'b010,
        VBC_XFER = 3'b011,
        VBC_LOAD = 3'b100
    } vbc_state_t;
endpackage : vbc_pkg

// [hdl/vbc_sequencer.sv]
/*
 Register file and band search calibration sequencer of the synthesizer.
 Assumes writes come one per cycle from the main serial port decoder,
 a reference edge strobe, a VCO edge strobe and a lock flag on ref_clk.
*/
module vbc_sequencer (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [vbc_pkg::REG_W-1:0] wr_data,
    input wire logic [4:0] rd_addr,
    output logic [vbc_pkg::REG_W-1:0] rd_data,
    input wire logic ref_edge,
    input wire logic vco_edge,
    input wire logic lock_detect,
    output logic cal_busy,
    output logic out_mute,
    output logic [vbc_pkg::SW_W-1:0] vco_switch,
    output logic [vbc_pkg::ODIV_W-1:0] out_divider,
    output logic [vbc_pkg::GAIN_W-1:0] out_gain,
    output logic [vbc_pkg::REG_W-1:0] prescaler_int,
    output logic [vbc_pkg::FRAC_BITS-1:0] modulator_frac,
    output logic [vbc_pkg::REG_W-1:0] ref_divider,
    output logic osc_port_data,
    output logic osc_port_busy
);
    import vbc_pkg::*;

    function automatic logic [3:0] mlen_exp(input logic [2:0] code);
        mlen_exp = code[2] ? 4'(code) + 4'h1 : 4'(code);
    endfunction : mlen_exp

    function automatic logic [2:0] mclk_exp(input logic [1:0] code);
        case (code)
            2'h0: mclk_exp = 3'h0;
            2'h1: mclk_exp = 3'h2;
            2'h2: mclk_exp = 3'h4;
            default: mclk_exp = 3'h5;
        endcase
    endfunction : mclk_exp

    logic [REG_W-1:0] ref_q, int_q, frac_q, dsm_q, ld_q, cp_q, cal_q;
    logic [REG_W-1:0] exact_q, ldpin_q, sw_q, divg_q, ocfg_q;
    vbc_state_t st_q;
    logic [5:0] tick_div_q;
    logic tick;
    logic [7:0] wait_q;
    logic [2:0] rep_q;
    logic [2:0] meas_q;
    logic [BAND_BITS-1:0] trial_q;
    logic [BAND_BITS-1:0] bit_q;
    logic [8:0] win_q;
    logic [31:0] vcnt_q;
    logic [39:0] target;
    logic relock_used_q;
    logic lock_d1_q;
    logic trig_cal, trig_relock;
    logic xfer_sent_q;
    logic [REG_W-1:0] int_run_q;
    logic [FRAC_BITS-1:0] frac_run_q;
    logic [SW_W-1:0] sw_run_q;
    vbc_osc_port_if lnk ();

    vbc_osc_port u_port (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .lnk(lnk)
    );

    wire frac_mode = dsm_q[BIT_FRAC_MODE];
    wire cal_off = cal_q[BIT_CAL_OFF];
    wire freq_wr = wr_en && ((frac_mode && wr_addr == ADR_FRAC_DIV) ||
        (!frac_mode && wr_addr == ADR_INT_DIV));

    // Register file, writes applied in arrival order
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ref_q <= RST_REG;
            int_q <= RST_REG;
            frac_q <= RST_REG;
            dsm_q <= RST_REG;
            ld_q <= RST_REG;
            cp_q <= RST_REG;
            cal_q <= RST_REG;
            exact_q <= RST_REG;
            ldpin_q <= RST_REG;
            divg_q <= RST_REG;
            ocfg_q <= RST_REG;
        end else if (wr_en) begin
            if (wr_addr == ADR_REF_DIV) begin
                ref_q <= wr_data;
            end else if (wr_addr == ADR_INT_DIV) begin
                int_q <= wr_data;
            end else if (wr_addr == ADR_FRAC_DIV) begin
                frac_q <= wr_data;
            end else if (wr_addr == ADR_DSM_CFG) begin
                dsm_q <= wr_data;
            end else if (wr_addr == ADR_LD_CFG) begin
                ld_q <= wr_data;
            end else if (wr_addr == ADR_CP_CFG) begin
                cp_q <= wr_data;
            end else if (wr_addr == ADR_CAL_CFG) begin
                cal_q <= wr_data;
            end else if (wr_addr == ADR_EXACT_CFG) begin
                exact_q <= wr_data;
            end else if (wr_addr == ADR_LDPIN_CFG) begin
                ldpin_q <= wr_data;
            end else if (wr_addr == ADR_OUT_DIVG) begin
                divg_q <= wr_data;
            end else if (wr_addr == ADR_OUT_CFG) begin
                ocfg_q <= wr_data;
            end
        end
    end

    // Read mux
    always_comb begin
        if (rd_addr == ADR_REF_DIV) begin
            rd_data = ref_q;
        end else if (rd_addr == ADR_INT_DIV) begin
            rd_data = int_q;
        end else if (rd_addr == ADR_FRAC_DIV) begin
            rd_data = frac_q;
        end else if (rd_addr == ADR_DSM_CFG) begin
            rd_data = dsm_q;
        end else if (rd_addr == ADR_LD_CFG) begin
            rd_data = ld_q;
        end else if (rd_addr == ADR_CP_CFG) begin
            rd_data = cp_q;
        end else if (rd_addr == ADR_CAL_CFG) begin
            rd_data = cal_q;
        end else if (rd_addr == ADR_EXACT_CFG) begin
            rd_data = exact_q;
        end else if (rd_addr == ADR_LDPIN_CFG) begin
            rd_data = ldpin_q;
        end else if (rd_addr == ADR_SW_SET) begin
            rd_data = {sw_q[REG_W-1:SW_LSB+SW_W], sw_run_q, sw_q[0]};
        end else if (rd_addr == ADR_OUT_DIVG) begin
            rd_data = divg_q;
        end else if (rd_addr == ADR_OUT_CFG) begin
            rd_data = ocfg_q;
        end else begin
            rd_data = RST_REG;
        end
    end

    // Sequencer tick: one pulse per 2^m reference edges
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tick_div_q <= 6'h00;
        end else if (ref_edge) begin
            if (tick_div_q >= 6'((1 << mclk_exp(cal_q[MCLK_LSB+:2])) - 1)) begin
                tick_div_q <= 6'h00;
            end else begin
                tick_div_q <= tick_div_q + 6'h01;
            end
        end
    end
    assign tick = ref_edge &&
        tick_div_q >= 6'((1 << mclk_exp(cal_q[MCLK_LSB+:2])) - 1);

    // Loss of lock triggers one relock attempt per frequency write
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lock_d1_q <= 1'b0;
            relock_used_q <= 1'b0;
        end else begin
            lock_d1_q <= lock_detect;
            if (trig_relock) begin
                relock_used_q <= 1'b1;
            end else if (freq_wr) begin
                relock_used_q <= 1'b0;
            end
        end
    end
    assign trig_relock = cal_q[BIT_RELOCK] && !cal_off && lock_d1_q && !lock_detect &&
        !relock_used_q && st_q == VBC_IDLE;
    assign trig_cal = (freq_wr && !cal_off) || trig_relock;

    // Expected VCO count: N * 2^n, N = int + frac/2^24 in fractional mode, int in integer mode
    assign target = ({int_q[15:0], frac_mode ? frac_q : 24'h000000} <<
        mlen_exp(cal_q[MLEN_LSB+:3])) >> FRAC_BITS;

    // Band search state machine
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_q <= VBC_IDLE;
            wait_q <= 8'h00;
            rep_q <= 3'h0;
            meas_q <= 3'h0;
            trial_q <= '0;
            bit_q <= '0;
            win_q <= 9'h000;
            vcnt_q <= 32'h0;
            xfer_sent_q <= 1'b0;
            sw_q <= RST_REG;
        end else begin
            case (st_q)
                VBC_IDLE: begin
                    if (trig_cal) begin
                        st_q <= VBC_SETTLE;
                        wait_q <= 8'h00;
                        rep_q <= 3'h0;
                        meas_q <= 3'h0;
                        bit_q <= {1'b1, {(BAND_BITS-1){1'b0}}};
                        trial_q <= {1'b1, {(BAND_BITS-1){1'b0}}};
                    end
                end
                VBC_SETTLE: begin
                    if (tick) begin
                        if (wait_q == 8'(SETTLE_TICKS - 1)) begin
                            wait_q <= 8'h00;
                            if (rep_q == 3'(SETTLE_COUNT - 1)) begin
                                st_q <= VBC_MEAS;
                                win_q <= 9'h000;
                                vcnt_q <= 32'h0;
                            end
                            rep_q <= rep_q + 3'h1;
                        end else begin
                            wait_q <= wait_q + 8'h01;
                        end
                    end
                end
                VBC_MEAS: begin
                    if (vco_edge) begin
                        vcnt_q <= vcnt_q + 32'h1;
                    end
                    if (ref_edge) begin
                        if (win_q == 9'((1 << mlen_exp(cal_q[MLEN_LSB+:3])) - 1)) begin
                            meas_q <= meas_q + 3'h1;
                            if (vcnt_q > target[31:0]) begin
                                trial_q <= trial_q - bit_q + (bit_q >> 1);
                            end else begin
                                trial_q <= trial_q | (bit_q >> 1);
                            end
                            bit_q <= bit_q >> 1;
                            st_q <= VBC_XFER;
                            xfer_sent_q <= 1'b0;
                        end else begin
                            win_q <= win_q + 9'h001;
                        end
                    end
                end
                VBC_XFER: begin
                    if (!xfer_sent_q) begin
                        xfer_sent_q <= lnk.busy;
                    end else if (lnk.done) begin
                        if (meas_q >= 3'(MEAS_MAX) || bit_q == '0) begin
                            st_q <= VBC_LOAD;
                        end else begin
                            st_q <= VBC_MEAS;
                            win_q <= 9'h000;
                            vcnt_q <= 32'h0;
                        end
                    end
                end
                default: begin
                    st_q <= VBC_IDLE;
                    sw_q[SW_LSB+:SW_W] <= SW_W'(trial_q);
                end
            endcase
            if (wr_en && wr_addr == ADR_SW_SET) begin
                sw_q <= wr_data;
            end
        end
    end

    assign lnk.tick = tick;
    assign lnk.start = st_q == VBC_XFER && !xfer_sent_q;
    assign lnk.word = {4'h0, 3'(meas_q), 1'b0, SW_W'(trial_q)};

    // Running divider and switch values
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            int_run_q <= RST_REG;
            frac_run_q <= '0;
            sw_run_q <= '0;
        end else begin
            if (wr_en && wr_addr == ADR_SW_SET && cal_off) begin
                sw_run_q <= wr_data[SW_LSB+:SW_W];
            end else if (st_q == VBC_XFER || st_q == VBC_LOAD) begin
                sw_run_q <= SW_W'(trial_q);
            end
            if (cal_off && wr_en && wr_addr == ADR_INT_DIV) begin
                int_run_q <= wr_data;
            end else if (cal_off && wr_en && wr_addr == ADR_FRAC_DIV) begin
                frac_run_q <= wr_data;
            end else if (st_q == VBC_LOAD) begin
                int_run_q <= int_q;
                frac_run_q <= frac_q;
            end else if (!cal_off && wr_en && !frac_mode && wr_addr == ADR_FRAC_DIV) begin
                frac_run_q <= wr_data;
            end
        end
    end

    assign cal_busy = st_q != VBC_IDLE;
    assign out_mute = divg_q[ODIV_LSB+:ODIV_W] == '0 ||
        (ocfg_q[BIT_CAL_MUTE] && cal_busy);
    assign vco_switch = sw_run_q;
    assign out_divider = divg_q[ODIV_LSB+:ODIV_W];
    assign out_gain = divg_q[GAIN_LSB+:GAIN_W];
    assign prescaler_int = int_run_q;
    assign modulator_frac = frac_run_q;
    assign ref_divider = ref_q;
    assign osc_port_data = lnk.sdata;
    assign osc_port_busy = lnk.busy;
endmodule : vbc_sequencer

// [testbench/vbc_host_model.sv]
/*
 Host model: main port writes in frequency-change order, reference and VCO pulses.
 Assumes the bench seeds the generator and calls the tasks after reset.
*/
module vbc_host_model
    import vbc_pkg::*;
#(
    parameter int REF_P = 4
) (
    input wire logic ref_clk,
    output logic wr_en,
    output logic [4:0] wr_addr,
    output logic [vbc_pkg::REG_W-1:0] wr_data,
    output logic ref_edge,
    output logic vco_edge
);
    timeunit 1ns;
    timeprecision 100ps;
    int ref_cnt = 0;
    initial begin
        wr_en = 1'b0;
        wr_addr = 5'h00;
        wr_data = 24'h000000;
        ref_edge = 1'b0;
        vco_edge = 1'b0;
    end
    // Comparison edge every REF_P clocks, VCO cycles at random
    always @(posedge ref_clk) begin
        #1;
        ref_cnt = (ref_cnt + 1) % REF_P;
        ref_edge = (ref_cnt == 0);
        vco_edge = 1'($urandom_range(1, 0));
    end
    task automatic write_reg(input logic [4:0] a, input logic [REG_W-1:0] d);
        @(posedge ref_clk);
        #1;
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(posedge ref_clk);
        #1;
        wr_en = 1'b0;
        wr_addr = ~a;
        wr_data = ~d;
    endtask : write_reg
    task automatic hop(input logic fr, input logic off, input logic [REG_W-1:0] iv,
        input logic [SW_W-1:0] sw, input logic [REG_W-1:0] dg, input logic [REG_W-1:0] fv);
        if (fr) write_reg(ADR_INT_DIV, iv);
        if (off) write_reg(ADR_SW_SET, {15'h0000, sw, 1'b0});
        write_reg(ADR_OUT_DIVG, dg);
        if (fr) write_reg(ADR_FRAC_DIV, fv);
        else write_reg(ADR_INT_DIV, iv);
    endtask : hop
endmodule : vbc_host_model

// [testbench/vbc_sequencer_chk.sv]
/*
 Port checker of vbc_sequencer: manual loads, calibration start, mute and fields.
 Assumes it is bound to the sequencer and sees only its top ports.
*/
module vbc_sequencer_chk
    import vbc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [vbc_pkg::REG_W-1:0] wr_data,
    input wire logic [4:0] rd_addr,
    input wire logic [vbc_pkg::REG_W-1:0] rd_data,
    input wire logic lock_detect,
    input wire logic cal_busy,
    input wire logic out_mute,
    input wire logic [vbc_pkg::SW_W-1:0] vco_switch,
    input wire logic [vbc_pkg::ODIV_W-1:0] out_divider,
    input wire logic [vbc_pkg::GAIN_W-1:0] out_gain,
    input wire logic [vbc_pkg::REG_W-1:0] prescaler_int,
    input wire logic [vbc_pkg::FRAC_BITS-1:0] modulator_frac,
    input wire logic [vbc_pkg::REG_W-1:0] ref_divider
);
    timeunit 1ns;
    timeprecision 100ps;
    logic frac_mode_q;
    logic cal_off_q;
    logic cal_mute_q;
    logic idle_wr;
    assign idle_wr = wr_en && !cal_busy;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // Shadow of the mode bits the sequencer acts on
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            frac_mode_q <= 1'b0;
            cal_off_q <= 1'b0;
            cal_mute_q <= 1'b0;
        end else if (wr_en) begin
            if (wr_addr == ADR_DSM_CFG) frac_mode_q <= wr_data[BIT_FRAC_MODE];
            if (wr_addr == ADR_CAL_CFG) cal_off_q <= wr_data[BIT_CAL_OFF];
            if (wr_addr == ADR_OUT_CFG) cal_mute_q <= wr_data[BIT_CAL_MUTE];
        end
    end
    sequence s_frac_go;
        idle_wr && wr_addr == ADR_FRAC_DIV && frac_mode_q && !cal_off_q;
    endsequence
    sequence s_int_go;
        idle_wr && wr_addr == ADR_INT_DIV && !frac_mode_q && !cal_off_q;
    endsequence
    AST_FRAC_CAL_START: assert property (s_frac_go |=> cal_busy [*2])
        else $error("fraction write did not start calibration");
    AST_INT_CAL_START: assert property (s_int_go |=> cal_busy [*2])
        else $error("integer write did not start calibration");
    AST_FRAC_MANUAL: assert property (idle_wr && wr_addr == ADR_FRAC_DIV && frac_mode_q
        && cal_off_q |=> modulator_frac == $past(wr_data) && !cal_busy)
        else $error("manual fraction not loaded at once");
    AST_INT_MANUAL: assert property (idle_wr && wr_addr == ADR_INT_DIV && !frac_mode_q
        && cal_off_q |=> prescaler_int == $past(wr_data) && !cal_busy)
        else $error("manual integer not loaded at once");
    AST_SW_MANUAL: assert property (idle_wr && wr_addr == ADR_SW_SET && cal_off_q
        |=> vco_switch == SW_W'($past(wr_data) >> SW_LSB))
        else $error("manual switch not applied at once");
    AST_DIV_FIELDS: assert property (idle_wr && wr_addr == ADR_OUT_DIVG |=>
        out_divider == ODIV_W'($past(wr_data)) && out_gain == GAIN_W'($past(wr_data) >> GAIN_LSB))
        else $error("divider or gain field wrong");
    AST_ALWAYS_MUTE: assert property (out_divider == 6'h00 |-> out_mute)
        else $error("zero divider not muted");
    AST_CAL_MUTE: assert property (cal_busy && cal_mute_q |-> out_mute)
        else $error("output live during calibration");
    AST_UNMUTE: assert property (!cal_busy && out_divider != 6'h00 && lock_detect
        |-> !out_mute)
        else $error("mute held while idle");
    AST_SW_READ: assert property (!cal_busy && rd_addr == ADR_SW_SET |->
        rd_data[SW_LSB +: SW_W] == vco_switch)
        else $error("switch readback differs");
    AST_REF_DIV: assert property (wr_en && wr_addr == ADR_REF_DIV |=>
        ref_divider == $past(wr_data))
        else $error("reference divider not taken");
endmodule : vbc_sequencer_chk

bind vbc_sequencer vbc_sequencer_chk i_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
    .rd_data(rd_data), .lock_detect(lock_detect), .cal_busy(cal_busy), .out_mute(out_mute),
    .vco_switch(vco_switch), .out_divider(out_divider), .out_gain(out_gain),
    .prescaler_int(prescaler_int), .modulator_frac(modulator_frac), .ref_divider(ref_divider));

// [testbench/vbc_sequencer_tb_top.sv]
/*
 Self-checking bench of vbc_sequencer: registers, manual loads, calibration timing, relock.
 Assumes vbc_pkg, the host model and the bound checker are compiled first.
*/
module vbc_sequencer_tb_top
    import vbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int REF_P = 4;
    localparam logic [4:0] PLAIN [6] = '{ADR_REF_DIV, ADR_LD_CFG, ADR_CP_CFG, ADR_EXACT_CFG,
        ADR_LDPIN_CFG, ADR_OUT_CFG};
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic lock_detect = 1'b1;
    logic [4:0] rd_addr = 5'h00;
    logic wr_en, ref_edge, vco_edge, cal_busy, out_mute, osc_port_busy, osc_port_data;
    logic [4:0] wr_addr;
    logic [REG_W-1:0] wr_data, rd_data, prescaler_int, ref_divider;
    logic [SW_W-1:0] vco_switch;
    logic [ODIV_W-1:0] out_divider;
    logic [GAIN_W-1:0] out_gain;
    logic [FRAC_BITS-1:0] modulator_frac;
    int miscompares = 0;
    int compares = 0;
    always #2.5 ref_clk = ~ref_clk;
    vbc_host_model #(.REF_P(REF_P)) i_host (.ref_clk(ref_clk), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .ref_edge(ref_edge), .vco_edge(vco_edge));
    vbc_sequencer i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
        .ref_edge(ref_edge), .vco_edge(vco_edge), .lock_detect(lock_detect),
        .cal_busy(cal_busy), .out_mute(out_mute), .vco_switch(vco_switch),
        .out_divider(out_divider), .out_gain(out_gain), .prescaler_int(prescaler_int),
        .modulator_frac(modulator_frac), .ref_divider(ref_divider),
        .osc_port_data(osc_port_data),
        .osc_port_busy(osc_port_busy));
    function automatic int n_of(input int c);
        return (c < 4) ? c : c + 1;
    endfunction : n_of
    function automatic int m_of(input int f);
        return (f == 0) ? 0 : (f == 1) ? 2 : (f == 2) ? 4 : 5;
    endfunction : m_of
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        compares++;
        if (g < lo || g > hi) begin
            miscompares++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_rng
    task automatic rd(input logic [4:0] a, output logic [23:0] d);
        rd_addr = a;
        @(posedge ref_clk);
        #1;
        d = rd_data;
    endtask : rd
    task automatic run_cal(input int ml, input int mf, input bit fr);
        logic [23:0] v;
        int cyc, xf, lo, hi;
        logic pb;
        logic [1:0] ds;
        v = fr ? 24'($urandom()) : 24'($urandom_range(200, 20));
        lo = (384 * (1 << m_of(mf)) + 5 * (1 << n_of(ml))) * REF_P - 8;
        // A few clock cycles of slack for pulse phase
        hi = (532 * (1 << m_of(mf)) + 6 * (1 << n_of(ml))) * REF_P + 8;
        i_host.write_reg(ADR_CAL_CFG, 24'((mf << MCLK_LSB) | ml));
        i_host.write_reg(ADR_DSM_CFG, 24'(fr) << BIT_FRAC_MODE);
        i_host.hop(fr, 1'b0, fr ? 24'd40 : v, 8'h00, 24'h000042, v);
        chk("cal_busy", 24'h1, 24'(cal_busy));
        chk("out_mute", 24'h1, 24'(out_mute));
        cyc = 0;
        xf = 0;
        pb = 1'b0;
        ds = 2'b00;
        while (cal_busy === 1'b1 && cyc < 40000) begin
            @(posedge ref_clk);
            #1;
            cyc++;
            xf += (osc_port_busy === 1'b1 && pb === 1'b0);
            pb = osc_port_busy;
            // Data may only be high inside a transfer
            ds[0] |= (osc_port_data === 1'b1 && osc_port_busy === 1'b1);
            ds[1] |= (osc_port_data === 1'b1 && osc_port_busy !== 1'b1);
        end
        chk_rng("cal_cycles", lo, hi, cyc);
        chk_rng("transfers", 5, 7, xf);
        chk("freq", v, fr ? modulator_frac : prescaler_int);
        chk("out_mute", 24'h0, 24'(out_mute));
        chk("osc_port_data", 24'h1, 24'(ds));
        rd(ADR_SW_SET, v);
        chk("sw_read", {16'h0000, 3'h0, vco_switch[4:0]}, 24'(v[SW_LSB+:SW_W]));
        $display("test cal %0d/%0d done", ml, mf);
    endtask : run_cal
    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    initial begin
        logic [23:0] d, p;
        void'($urandom(32'hD7B0617C));
        repeat (3) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        chk("out_mute", 24'h1, 24'(out_mute));
        chk("cal_busy", 24'h0, 24'(cal_busy));
        $display("test reset done");
        foreach (PLAIN[i]) begin
            p = 24'($urandom());
            i_host.write_reg(PLAIN[i], p);
            rd(PLAIN[i], d);
            chk("reg", p, d);
        end
        rd(5'h1F, d);
        chk("unmapped", 24'h0, d);
        for (int k = 0; k < 3; k++) begin
            p = 24'($urandom());
            p[5:0] = (k == 1) ? 6'h00 : p[5:0];
            i_host.write_reg(ADR_OUT_DIVG, p);
            chk("out_divider", 24'(p[5:0]), 24'(out_divider));
            chk("out_gain", 24'(p[10:6]), 24'(out_gain));
            chk("out_mute", 24'(p[5:0] == 6'h00), 24'(out_mute));
        end
        $display("test registers done");
        i_host.write_reg(ADR_CAL_CFG, 24'h000800);
        for (int f = 0; f < 2; f++) begin
            p = 24'($urandom());
            d = 24'($urandom_range(255, 0));
            i_host.write_reg(ADR_DSM_CFG, 24'(f) << BIT_FRAC_MODE);
            i_host.hop(f[0], 1'b1, 24'd50, d[7:0], 24'h000043, p);
            chk("vco_switch", d, 24'(vco_switch));
            chk("freq", f ? p : 24'd50, f ? modulator_frac : prescaler_int);
            chk("cal_busy", 24'h0, 24'(cal_busy));
        end
        $display("test manual done");
        i_host.write_reg(ADR_OUT_CFG, 24'h1 << BIT_CAL_MUTE);
        for (int i = 0; i < 10; i++) begin
            run_cal(i % 8, i / 8, i[0]);
        end
        i_host.write_reg(ADR_CAL_CFG, (24'h1 << BIT_RELOCK) | 24'h000004);
        for (int j = 0; j < 2; j++) begin
            lock_detect = 1'b0;
            repeat (16) @(posedge ref_clk);
            #1;
            chk("relock", 24'(j == 0), 24'(cal_busy));
            lock_detect = 1'b1;
            for (int k = 0; k < 40000 && cal_busy === 1'b1; k++) @(posedge ref_clk);
            #1;
        end
        $display("test relock done");
        complete_run();
    end
    initial begin
        #450000;
        miscompares++;
        $display("Error watchdog expected done seen hang");
        complete_run();
    end
endmodule : vbc_sequencer_tb_top
